// ---- rtl/capture_compare_unit.sv ----
// One capture/compare unit; the device holds four copies of this module.
// Assumes timers, sources and software writes arrive synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module capture_compare_unit #(
	parameter int WIDTH = 16 // Timer and value width
) (
	input wire logic sys_clk, // System clock, 200 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [3:0] unit_mode_field, // Mode field of the control register
	input wire logic unit_enable, // Module on bit of the control register
	input wire logic [3:0] capture_source_select, // Capture source choice
	input wire logic [1:0] pwm_timebase_select, // Pulse-width timebase choice
	input wire logic timer_select, // 0: timer zero, 1: timer one
	input wire logic [WIDTH-1:0] timer_zero_count_pair, // Timer zero count
	input wire logic [WIDTH-1:0] timer_one_count_pair, // Timer one count
	input wire logic remapped_pin_input, // Pin input, includes port write echo
	input wire logic comparator_one_result, // Comparator 1
	input wire logic comparator_two_result, // Comparator 2
	input wire logic numeric_oscillator, // Oscillator output
	input wire logic pin_change_event, // Pin change event
	input wire logic logic_cell_one_result, // Logic cell 1
	input wire logic logic_cell_two_result, // Logic cell 2
	input wire logic logic_cell_three_result, // Logic cell 3
	input wire logic logic_cell_four_result, // Logic cell 4
	input wire logic value_write, // Software write of value pair
	input wire logic [WIDTH-1:0] value_wdata, // Data for the value pair
	input wire logic irq_flag_clear, // Software clear of the flag
	output logic [WIDTH-1:0] capture_compare_value_pair, // Stored value
	output logic unit_irq_flag, // Sticky interrupt flag
	output logic compare_output, // Compare output latch
	output logic conversion_trigger, // One-cycle conversion trigger
	output logic [1:0] pwm_timebase // Chosen 8-bit timer for pulse width
);

	////////////////////////////////////////////////////////////////////////
	// Decoding

	// Mode classes
	wire logic is_rise4 = (unit_mode_field == ccu_pkg::MODE_CAP_RISE4);
	wire logic is_rise16 = (unit_mode_field == ccu_pkg::MODE_CAP_RISE16);
	wire logic is_fall = (unit_mode_field == ccu_pkg::MODE_CAP_FALL);
	wire logic is_rise1 = (unit_mode_field == ccu_pkg::MODE_CAP_RISE);
	wire logic capture_mode = unit_enable && (is_fall || is_rise1 || is_rise4 || is_rise16);
	wire logic compare_mode = unit_enable && (unit_mode_field == ccu_pkg::MODE_CMP_TOGGLE
		|| unit_mode_field == ccu_pkg::MODE_CMP_SET || unit_mode_field == ccu_pkg::MODE_CMP_CLEAR
		|| unit_mode_field == ccu_pkg::MODE_CMP_SOFT || unit_mode_field == ccu_pkg::MODE_CMP_TRIG);

	// Reference timer
	wire logic [WIDTH-1:0] ref_count = timer_select ? timer_one_count_pair : timer_zero_count_pair;

	// Source mux; an echo of a port write on remapped_pin_input captures too
	logic src_level;
	always_comb begin
		if (capture_source_select == ccu_pkg::SRC_PIN) begin
			src_level = remapped_pin_input;
		end else if (capture_source_select == ccu_pkg::SRC_CMP1) begin
			src_level = comparator_one_result;
		end else if (capture_source_select == ccu_pkg::SRC_CMP2) begin
			src_level = comparator_two_result;
		end else if (capture_source_select == ccu_pkg::SRC_OSC) begin
			src_level = numeric_oscillator;
		end else if (capture_source_select == ccu_pkg::SRC_PCHG) begin
			src_level = pin_change_event;
		end else if (capture_source_select == ccu_pkg::SRC_LC1) begin
			src_level = logic_cell_one_result;
		end else if (capture_source_select == ccu_pkg::SRC_LC2) begin
			src_level = logic_cell_two_result;
		end else if (capture_source_select == ccu_pkg::SRC_LC3) begin
			src_level = logic_cell_three_result;
		end else if (capture_source_select == ccu_pkg::SRC_LC4) begin
			src_level = logic_cell_four_result;
		end else begin
			src_level = 1'b0; // Unused codes give a quiet source
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge detection and prescaler

	logic src_prev; // Source level one cycle ago
	logic [3:0] pre_count; // Qualifying rising edge count
	wire logic rise = src_level && !src_prev;
	wire logic fall = !src_level && src_prev;
	wire logic [3:0] pre_last = is_rise16 ? ccu_pkg::PRE_DIV16_LAST : ccu_pkg::PRE_DIV4_LAST;
	wire logic divided = is_rise4 || is_rise16;
	wire logic pre_hit = (pre_count >= pre_last); // Also catches a count left high by a setting change
	// Capture event per mode
	wire logic capture_event = capture_mode && ((is_fall && fall) || (is_rise1 && rise)
		|| (divided && rise && pre_hit));

	// Previous source level; kept in all modes so enabling sees no false edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= src_level;
		end
	end

	// Prescaler; a change between divided settings keeps the count
	always_ff @(posedge sys_clk) begin
		if (srst || !capture_mode) begin
			pre_count <= ccu_pkg::PRE_RESET;
		end else if (divided && rise) begin
			pre_count <= pre_hit ? ccu_pkg::PRE_RESET : pre_count + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare

	wire logic match = compare_mode && (capture_compare_value_pair == ref_count);
	logic match_prev; // Match one cycle ago, so a held match acts once
	wire logic match_event = match && !match_prev;

	// Match history
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			match_prev <= 1'b0;
		end else begin
			match_prev <= match;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Value pair

	// Capture wins over a software write in the same cycle
	// A timer held still (sleep) is taken as it stands, no special path
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			capture_compare_value_pair <= ccu_pkg::VALUE_RESET;
		end else if (capture_event) begin
			capture_compare_value_pair <= ref_count;
		end else if (value_write) begin
			capture_compare_value_pair <= value_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag, output latch, trigger

	// Set beats clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			unit_irq_flag <= 1'b0;
		end else if (capture_event || match_event) begin
			unit_irq_flag <= 1'b1;
		end else if (irq_flag_clear) begin
			unit_irq_flag <= 1'b0;
		end
	end

	// Output latch; a zeroed control forces it low
	always_ff @(posedge sys_clk) begin
		if (srst || (!unit_enable && unit_mode_field == ccu_pkg::MODE_OFF)) begin
			compare_output <= 1'b0;
		end else if (match_event) begin
			case (unit_mode_field)
				ccu_pkg::MODE_CMP_TOGGLE: compare_output <= !compare_output;
				ccu_pkg::MODE_CMP_SET: compare_output <= 1'b1;
				ccu_pkg::MODE_CMP_CLEAR: compare_output <= 1'b0;
				default: compare_output <= compare_output; // No pin change
			endcase
		end
	end

	// Trigger pulse on every match
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			conversion_trigger <= 1'b0;
		end else begin
			conversion_trigger <= match_event;
		end
	end

	// Timebase select held per unit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pwm_timebase <= 2'h0;
		end else begin
			pwm_timebase <= pwm_timebase_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_capture;
		capture_event ##1 1'b1;
	endsequence

	a_capture_loads: assert property (@(posedge sys_clk) disable iff (srst)
		capture_event |=> capture_compare_value_pair == $past(ref_count))
		else $error("capture did not load timer");
	a_capture_flag: assert property (@(posedge sys_clk) disable iff (srst)
		s_capture |-> unit_irq_flag)
		else $error("capture did not set flag");
	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (srst)
		unit_irq_flag && !irq_flag_clear |=> unit_irq_flag)
		else $error("flag dropped without clear");
	a_prescale_clear: assert property (@(posedge sys_clk) disable iff (srst)
		!capture_mode |=> pre_count == 4'h0)
		else $error("prescaler not cleared");
	a_prescale_bound: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && is_rise4 && pre_count <= 4'h3 |=> pre_count <= 4'h3)
		else $error("divide by four overran");
	a_fall_capture: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && is_fall && rise |-> !capture_event)
		else $error("rising edge captured in falling mode");
	a_match_trigger: assert property (@(posedge sys_clk) disable iff (srst)
		match_event |=> conversion_trigger && unit_irq_flag)
		else $error("match without trigger and flag");
	a_toggle_out: assert property (@(posedge sys_clk) disable iff (srst)
		match_event && unit_mode_field == ccu_pkg::MODE_CMP_TOGGLE |=> compare_output != $past(compare_output))
		else $error("toggle did not toggle");
	a_zero_low: assert property (@(posedge sys_clk) disable iff (srst)
		!unit_enable && unit_mode_field == ccu_pkg::MODE_OFF |=> !compare_output)
		else $error("output not forced low");

	// Capture event selection and the divided count
	a_rise_capture: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && is_rise1 && rise |-> capture_event)
		else $error("rising edge missed in rising mode");
	a_div4_capture: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && is_rise4 && rise && pre_count == 4'h3 |-> capture_event)
		else $error("fourth rising edge did not capture");
	a_div_restart: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && divided && rise && pre_hit |=> pre_count == 4'h0)
		else $error("prescaler did not restart");
	a_div_count: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && divided && rise && !pre_hit |=> pre_count == $past(pre_count) + 4'h1)
		else $error("prescaler did not count edge");
	// Count survives a change of divided setting, which may give a false capture
	a_prescale_keep: assert property (@(posedge sys_clk) disable iff (srst)
		capture_mode && !rise |=> pre_count == $past(pre_count))
		else $error("prescaler lost its count");

	// Timer standing still across the capture edge
	sequence s_capture_held;
		capture_event ##1 $stable(ref_count);
	endsequence
	a_held_timer: assert property (@(posedge sys_clk) disable iff (srst)
		s_capture_held |-> capture_compare_value_pair == ref_count)
		else $error("held timer not captured as it stands");

	// Source choice
	a_source_pin: assert property (@(posedge sys_clk) disable iff (srst)
		capture_source_select == ccu_pkg::SRC_PIN |-> src_level == remapped_pin_input)
		else $error("pin source not routed");
	a_source_cmp1: assert property (@(posedge sys_clk) disable iff (srst)
		capture_source_select == ccu_pkg::SRC_CMP1 |-> src_level == comparator_one_result)
		else $error("comparator source not routed");
	a_flag_clear: assert property (@(posedge sys_clk) disable iff (srst)
		irq_flag_clear && !capture_event && !match_event |=> !unit_irq_flag)
		else $error("flag clear ignored");

	// Compare: start of equality, then its effects
	sequence s_match_start;
		compare_mode && capture_compare_value_pair == ref_count && !match_prev;
	endsequence
	a_match_detect: assert property (@(posedge sys_clk) disable iff (srst)
		s_match_start |=> unit_irq_flag && conversion_trigger)
		else $error("equality not detected as match");
	a_match_once: assert property (@(posedge sys_clk) disable iff (srst)
		match && match_prev |=> !conversion_trigger)
		else $error("held match triggered again");
	a_set_out: assert property (@(posedge sys_clk) disable iff (srst)
		match_event && unit_mode_field == ccu_pkg::MODE_CMP_SET |=> compare_output)
		else $error("set mode did not set output");
	a_clear_out: assert property (@(posedge sys_clk) disable iff (srst)
		match_event && unit_mode_field == ccu_pkg::MODE_CMP_CLEAR |=> !compare_output)
		else $error("clear mode did not clear output");
	a_keep_out: assert property (@(posedge sys_clk) disable iff (srst)
		match_event && (unit_mode_field == ccu_pkg::MODE_CMP_SOFT
		|| unit_mode_field == ccu_pkg::MODE_CMP_TRIG) |=> $stable(compare_output))
		else $error("quiet mode moved output");
	a_timebase_follow: assert property (@(posedge sys_clk) disable iff (srst)
		1'b1 |=> pwm_timebase == $past(pwm_timebase_select))
		else $error("timebase select not held");

endmodule

`default_nettype wire

// ---- rtl/ccu_pkg.sv ----
// Constants shared by the capture/compare unit.
// Assumes one system clock; no register bus, control bits are plain ports.
package ccu_pkg;
	// Mode field encodings (4 bits)
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
	localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
	// Capture source select encodings
	localparam logic [3:0] SRC_PIN = 4'h0;
	localparam logic [3:0] SRC_CMP1 = 4'h1;
	localparam logic [3:0] SRC_CMP2 = 4'h2;
	localparam logic [3:0] SRC_OSC = 4'h3;
	localparam logic [3:0] SRC_PCHG = 4'h4;
	localparam logic [3:0] SRC_LC1 = 4'h5;
	localparam logic [3:0] SRC_LC2 = 4'h6;
	localparam logic [3:0] SRC_LC3 = 4'h7;
	localparam logic [3:0] SRC_LC4 = 4'h8;
	// Prescale terminal counts
	localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
	localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
	// Reset values
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [3:0] PRE_RESET = 4'h0;
endpackage

// ---- tb/capture_compare_unit_tb_top.sv ----
// Bench for one capture/compare unit: capture sweep, prescale, compare actions.
// Assumes timers are held still while a capture or a match is checked.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module capture_compare_unit_tb_top;
	logic sys_clk = 0, srst = 1, en = 0, tsel = 0, vw = 0, fclr = 0, hold = 1, load = 0, eo = 0;
	logic [3:0] mode = 4'h0, css = 4'h0;
	logic [1:0] pts = 2'h0, ptb;
	logic [8:0] srcs = 9'h000; // Index equals the source select code
	logic [15:0] vd = 16'h0000, lval = 16'h0000, rnd = 16'h0029, t0, t1, pair;
	logic flag, cout, trig;
	logic [3:0] cm [7] = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_SOFT, ccu_pkg::MODE_CMP_TRIG,
		ccu_pkg::MODE_CMP_TOGGLE, ccu_pkg::MODE_CMP_TOGGLE, ccu_pkg::MODE_CMP_CLEAR, ccu_pkg::MODE_CMP_SET};
	int bad_count = 0, n_tests = 0, trig_n = 0;
	timer_source_model u_timer_source_model (.sys_clk(sys_clk), .srst(srst), .hold(hold), .load(load),
		.load_val(lval), .t0(t0), .t1(t1));
	capture_compare_unit u_capture_compare_unit (.sys_clk(sys_clk), .srst(srst), .unit_mode_field(mode),
		.unit_enable(en), .capture_source_select(css), .pwm_timebase_select(pts), .timer_select(tsel),
		.timer_zero_count_pair(t0), .timer_one_count_pair(t1), .remapped_pin_input(srcs[0]),
		.comparator_one_result(srcs[1]), .comparator_two_result(srcs[2]), .numeric_oscillator(srcs[3]),
		.pin_change_event(srcs[4]), .logic_cell_one_result(srcs[5]), .logic_cell_two_result(srcs[6]),
		.logic_cell_three_result(srcs[7]), .logic_cell_four_result(srcs[8]), .value_write(vw),
		.value_wdata(vd), .irq_flag_clear(fclr), .capture_compare_value_pair(pair), .unit_irq_flag(flag),
		.compare_output(cout), .conversion_trigger(trig), .pwm_timebase(ptb));
	////////////////////////////////////////
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Count trigger pulses; each match must give exactly one
	always @(posedge sys_clk) begin
		if (trig === 1'b1) trig_n++;
	end
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Count the selected timer shows after a preset
	function automatic logic [15:0] eref(input logic s, input logic [15:0] v);
		return s ? (v ^ 16'hA5A5) : v;
	endfunction
	function automatic logic exp_out(input logic [3:0] m, input logic prev);
		case (m)
			ccu_pkg::MODE_CMP_SET: return 1'b1;
			ccu_pkg::MODE_CMP_CLEAR: return 1'b0;
			ccu_pkg::MODE_CMP_TOGGLE: return ~prev;
			default: return prev; // No pin change
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic setm(input logic [3:0] m, input logic e);
		cyc(1);
		mode = m;
		en = e;
	endtask
	task automatic tset();
		cyc(1);
		rnd = nxt(rnd);
		lval = rnd;
		tsel = rnd[3];
		load = 1;
		cyc(1);
		load = 0;
	endtask
	task automatic wr(input logic [15:0] v);
		cyc(1);
		vw = 1;
		vd = v;
		cyc(1);
		vw = 0;
	endtask
	task automatic clr();
		cyc(1);
		fclr = 1;
		cyc(1);
		fclr = 0;
		cyc(1);
	endtask
	// Park all sources at the idle level, then move one to lv
	task automatic hit(input int i, input logic lv);
		cyc(1);
		srcs = {9{~lv}};
		cyc(2);
		srcs[i] = lv;
		cyc(3);
	endtask
	task automatic rises(input int n, input logic f);
		repeat (n) hit(0, 1'b1);
		`CHK(flag, f)
	endtask
	task automatic cmp(input logic [3:0] m);
		eo = exp_out(m, eo);
		tset();
		wr(~eref(tsel, lval)); // Move off the match before the mode changes
		setm(m, 1'b1);
		clr();
		trig_n = 0;
		wr(eref(tsel, lval));
		cyc(3);
		`CHK(cout, eo)
		`CHK(flag, 1'b1)
		`CHK(trig_n, 1)
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Tests need about 550 cycles; ten thousand leaves ample margin
	initial begin
		#50000;
		bad_count++;
		complete_run();
	end
	initial begin
		cyc(4);
		srst = 0;
		`CHK(pair, ccu_pkg::VALUE_RESET)
		`CHK(cout, 1'b0)
		// Every source, falling then rising edge, value and flag checked after each capture
		for (int s = 0; s < 18; s++) begin
			css = 4'(s / 2);
			setm(s[0] ? ccu_pkg::MODE_CAP_RISE : ccu_pkg::MODE_CAP_FALL, 1'b1);
			tset();
			hit(s / 2, s[0]);
			`CHK(pair, eref(tsel, lval))
			`CHK(flag, 1'b1)
			clr();
			`CHK(flag, 1'b0)
		end
		$display("capture sweep done");
		// A disabled unit refuses both edges and keeps its last value
		setm(ccu_pkg::MODE_CAP_RISE, 1'b0);
		hit(8, 1'b0);
		hit(8, 1'b1);
		`CHK(flag, 1'b0)
		`CHK(pair, eref(tsel, lval))
		setm(ccu_pkg::MODE_OFF, 1'b0);
		setm(ccu_pkg::MODE_CAP_RISE4, 1'b1);
		css = ccu_pkg::SRC_PIN;
		clr();
		rises(3, 1'b0);
		rises(1, 1'b1);
		clr();
		setm(ccu_pkg::MODE_CAP_RISE16, 1'b1);
		rises(15, 1'b0);
		rises(1, 1'b1);
		clr();
		rises(2, 1'b0);
		setm(ccu_pkg::MODE_OFF, 1'b0);
		setm(ccu_pkg::MODE_CAP_RISE4, 1'b1);
		rises(3, 1'b0);
		rises(1, 1'b1);
		clr();
		setm(ccu_pkg::MODE_CAP_RISE16, 1'b1);
		rises(5, 1'b0);
		setm(ccu_pkg::MODE_CAP_RISE4, 1'b1);
		rises(1, 1'b1);
		$display("prescale tests done");
		for (int k = 0; k < 7; k++) cmp(cm[k]);
		setm(ccu_pkg::MODE_OFF, 1'b0);
		cyc(2);
		`CHK(cout, 1'b0)
		for (int k = 0; k < 4; k++) begin
			rnd = nxt(rnd);
			pts = rnd[1:0];
			cyc(2);
			`CHK(ptb, pts)
		end
		$display("compare tests done");
		complete_run();
	end
endmodule
`default_nettype wire

// ---- tb/timer_source_model.sv ----
// Reference timer model: the two counts the unit captures from and compares against.
// Assumes the bench drives hold and load just after the falling edge.
`timescale 1ns/1ps
`default_nettype none
module timer_source_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic hold, // Sleep: counts stand still
	input wire logic load, // Preset both counts
	input wire logic [15:0] load_val,
	output logic [15:0] t0,
	output logic [15:0] t1
);
	logic [1:0] tick; // Instruction clock divider, never the raw system clock
	////////////////////////////////////////
	// Synchronous counting; step of one on every fourth cycle (tick == 3), so a divide by 4 on the count
	always_ff @(posedge sys_clk) begin
		if (srst || load) begin
			tick <= 2'h0;
			t0 <= srst ? 16'h0000 : load_val;
			t1 <= srst ? 16'h0000 : load_val ^ 16'hA5A5;
		end else if (!hold) begin
			tick <= tick + 2'h1;
			t0 <= t0 + {15'h0000, tick == 2'h3};
			t1 <= t1 + {15'h0000, tick == 2'h3};
		end
	end
endmodule
`default_nettype wire
